// *** verilog/rfet_map.svh ***
`ifndef RFET_MAP_SVH
`define RFET_MAP_SVH

// Register addresses
`define RFET_ADDR_NRT_HI 8'h0f
`define RFET_ADDR_NRT_LO 8'h10
`define RFET_ADDR_CTRL 8'h11
`define RFET_ADDR_GPT_HI 8'h12
`define RFET_ADDR_GPT_LO 8'h13
`define RFET_ADDR_MASK 8'h15
`define RFET_ADDR_MAIN_IRQ 8'h17

// Timer control field positions
`define RFET_CTRL_STEP 0
`define RFET_CTRL_EMV 1
`define RFET_CTRL_TRIG_HI 7
`define RFET_CTRL_TRIG_LO 5

// Mask and main interrupt bit positions
`define RFET_MASK_NRE 6
`define RFET_MASK_GPE 5
`define RFET_MAIN_TIM 1

// Reset values
`define RFET_RST_NRT 8'h00
`define RFET_RST_CTRL 8'h00
`define RFET_RST_GPT 8'h00
`define RFET_RST_MASK 8'h00

// Step sizes in carrier periods
`define RFET_NRT_STEP_FINE 64
`define RFET_NRT_STEP_COARSE 4096
`define RFET_GPT_STEP 8

// Trigger select codes
`define RFET_TRIG_CMD 3'h0
`define RFET_TRIG_RX_END 3'h1
`define RFET_TRIG_RX_START 3'h2
`define RFET_TRIG_TX_END_NFC 3'h3

`endif

// *** verilog/rfet_pkg.sv ***
package rfet_pkg;
  typedef logic [15:0] rfet_count_t;
  typedef enum logic [1:0] {
    ARM_IDLE,
    ARM_WAIT_FIELD
  } rfet_arm_e;
endpackage

// *** verilog/rfet_step_timer.sv ***
module rfet_step_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic start,
  input wire logic stop,
  input wire logic tick,
  input wire rfet_pkg::rfet_count_t load,
  output logic running_q,
  output logic expire_q
);

  rfet_pkg::rfet_count_t count_q;

  // A zero load never arms the timer
  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      count_q <= 16'h0000;
      running_q <= 1'b0;
    end else if (start && load != 16'h0000) begin
      count_q <= load;
      running_q <= 1'b1;
    end else if (stop) begin
      running_q <= 1'b0;
    end else if (running_q && tick) begin
      count_q <= count_q - 16'h0001;
      if (count_q == 16'h0001) begin
        running_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      expire_q <= 1'b0;
    end else begin
      expire_q <= running_q && tick && !stop && !start && count_q == 16'h0001;
    end
  end

  property p_expire_needs_run;
    @(posedge clk) disable iff (!rst_n)
      expire_q |-> !running_q && $past(running_q);
  endproperty
  a_expire_needs_run: assert property (p_expire_needs_run)
    else $error("expiry without a running timer");

endmodule // rfet_step_timer

// *** verilog/rfet_timers.sv ***
`include "rfet_map.svh"

module rfet_timers (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic FC_EN,
  input wire logic REG_WE,
  input wire logic REG_RE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic CMD_SET_DEFAULT,
  input wire logic CMD_START_NRT,
  input wire logic CMD_START_GPT,
  input wire logic NFC_MODE,
  input wire logic ACTIVE_P2P,
  input wire logic EXT_FIELD,
  input wire logic TX_END,
  input wire logic TX_OFF,
  input wire logic RX_START,
  input wire logic RX_END,
  output logic NRT_EXPIRED,
  output logic GPT_EXPIRED,
  output logic FIELD_OFF,
  output logic NRT_RUNNING,
  output logic GPT_RUNNING,
  output logic TIMER_IRQ
);

  logic [7:0] nrt_hi_q, nrt_lo_q, ctrl_q, gpt_hi_q, gpt_lo_q, mask_q;
  logic [2:0] field_sync_q, gpt_pre_q, trig;
  logic [11:0] nrt_pre_q;
  rfet_pkg::rfet_arm_e arm_q;
  logic field_on_q, field_trig_q, ev_nre_q, ev_gpe_q, tim_summary, status_read;
  logic nrt_expire, gpt_expire, nrt_start, nrt_stop, gpt_start, nrt_tick, gpt_tick, nrt_zero;
  rfet_pkg::rfet_count_t nrt_val, gpt_val;

  assign nrt_val = {nrt_hi_q, nrt_lo_q};
  assign gpt_val = {gpt_hi_q, gpt_lo_q};
  assign nrt_zero = nrt_val == 16'h0000;
  assign trig = ctrl_q[`RFET_CTRL_TRIG_HI:`RFET_CTRL_TRIG_LO];
  assign status_read = REG_RE && REG_ADDR == `RFET_ADDR_MAIN_IRQ;

  // Register file; set-default restores the same values as reset
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || CMD_SET_DEFAULT) begin
      nrt_hi_q <= `RFET_RST_NRT;
      nrt_lo_q <= `RFET_RST_NRT;
      ctrl_q <= `RFET_RST_CTRL;
      gpt_hi_q <= `RFET_RST_GPT;
      gpt_lo_q <= `RFET_RST_GPT;
      mask_q <= `RFET_RST_MASK;
    end else if (REG_WE) begin
      if (REG_ADDR == `RFET_ADDR_NRT_HI) begin
        nrt_hi_q <= REG_WDATA;
      end else if (REG_ADDR == `RFET_ADDR_NRT_LO) begin
        nrt_lo_q <= REG_WDATA;
      end else if (REG_ADDR == `RFET_ADDR_CTRL) begin
        // Bits 4..2 are unused and stay zero
        ctrl_q <= REG_WDATA & 8'he3;
      end else if (REG_ADDR == `RFET_ADDR_GPT_HI) begin
        gpt_hi_q <= REG_WDATA;
      end else if (REG_ADDR == `RFET_ADDR_GPT_LO) begin
        gpt_lo_q <= REG_WDATA;
      end else if (REG_ADDR == `RFET_ADDR_MASK) begin
        mask_q <= REG_WDATA & 8'h60;
      end
    end
  end

  // Read data is registered: valid the cycle after REG_RE
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RE) begin
      if (REG_ADDR == `RFET_ADDR_NRT_HI) begin
        REG_RDATA <= nrt_hi_q;
      end else if (REG_ADDR == `RFET_ADDR_NRT_LO) begin
        REG_RDATA <= nrt_lo_q;
      end else if (REG_ADDR == `RFET_ADDR_CTRL) begin
        REG_RDATA <= ctrl_q;
      end else if (REG_ADDR == `RFET_ADDR_GPT_HI) begin
        REG_RDATA <= gpt_hi_q;
      end else if (REG_ADDR == `RFET_ADDR_GPT_LO) begin
        REG_RDATA <= gpt_lo_q;
      end else if (REG_ADDR == `RFET_ADDR_MASK) begin
        REG_RDATA <= mask_q;
      end else if (REG_ADDR == `RFET_ADDR_MAIN_IRQ) begin
        REG_RDATA <= {6'h00, tim_summary, 1'b0};
      end else begin
        REG_RDATA <= 8'h00;
      end
    end
  end

  // Field detector is analog: three stages, accept when last two agree
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      field_sync_q <= 3'h0;
    end else begin
      field_sync_q <= {field_sync_q[1:0], EXT_FIELD};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      field_on_q <= 1'b0;
    end else if (field_sync_q[1] == field_sync_q[2]) begin
      field_on_q <= field_sync_q[2];
    end
  end

  // Response timer start sources; active peer mode takes precedence over NFC
  always_comb begin
    nrt_start = 1'b0;
    if (!nrt_zero) begin
      if (CMD_START_NRT) begin
        nrt_start = 1'b1;
      end else if (ACTIVE_P2P) begin
        nrt_start = TX_OFF;
      end else if (NFC_MODE) begin
        nrt_start = (TX_END || arm_q == rfet_pkg::ARM_WAIT_FIELD) && field_on_q;
      end else begin
        nrt_start = TX_END;
      end
    end
  end

  // In EMV mode a reply does not cancel the timer; expiry is still reported
  assign nrt_stop = RX_START && !ctrl_q[`RFET_CTRL_EMV] && !nrt_start;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || CMD_SET_DEFAULT) begin
      arm_q <= rfet_pkg::ARM_IDLE;
    end else begin
      case (arm_q)
        rfet_pkg::ARM_IDLE: begin
          if (TX_END && NFC_MODE && !ACTIVE_P2P && !field_on_q && !nrt_zero) begin
            arm_q <= rfet_pkg::ARM_WAIT_FIELD;
          end
        end
        rfet_pkg::ARM_WAIT_FIELD: begin
          if (nrt_start || !NFC_MODE || CMD_START_NRT || nrt_zero) begin
            arm_q <= rfet_pkg::ARM_IDLE;
          end
        end
        default: begin
          arm_q <= rfet_pkg::ARM_IDLE;
        end
      endcase
    end
  end

  // Prescalers restart with their timer so the first unit is whole
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || nrt_start) begin
      nrt_pre_q <= 12'h000;
    end else if (FC_EN) begin
      nrt_pre_q <= nrt_pre_q + 12'h001;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || gpt_start) begin
      gpt_pre_q <= 3'h0;
    end else if (FC_EN) begin
      gpt_pre_q <= gpt_pre_q + 3'h1;
    end
  end

  assign nrt_tick = FC_EN && (ctrl_q[`RFET_CTRL_STEP] ?
    nrt_pre_q == 12'(`RFET_NRT_STEP_COARSE - 1) :
    nrt_pre_q[5:0] == 6'(`RFET_NRT_STEP_FINE - 1));
  assign gpt_tick = FC_EN && gpt_pre_q == 3'(`RFET_GPT_STEP - 1);

  // Unused trigger codes fall through to command-only start
  always_comb begin
    gpt_start = CMD_START_GPT;
    if (trig == `RFET_TRIG_RX_END) begin
      gpt_start = CMD_START_GPT || RX_END;
    end else if (trig == `RFET_TRIG_RX_START) begin
      gpt_start = CMD_START_GPT || RX_START;
    end else if (trig == `RFET_TRIG_TX_END_NFC) begin
      gpt_start = CMD_START_GPT || (TX_END && NFC_MODE);
    end
  end

  // Remember whether the running general timer owns the field switch-off
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || CMD_SET_DEFAULT) begin
      field_trig_q <= 1'b0;
    end else if (gpt_start) begin
      field_trig_q <= trig == `RFET_TRIG_TX_END_NFC && TX_END && NFC_MODE;
    end
  end

  rfet_step_timer u_nrt (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .clr(CMD_SET_DEFAULT),
    .start(nrt_start),
    .stop(nrt_stop),
    .tick(nrt_tick),
    .load(nrt_val),
    .running_q(NRT_RUNNING),
    .expire_q(nrt_expire)
  );

  rfet_step_timer u_gpt (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .clr(CMD_SET_DEFAULT),
    .start(gpt_start),
    .stop(1'b0),
    .tick(gpt_tick),
    .load(gpt_val),
    .running_q(GPT_RUNNING),
    .expire_q(gpt_expire)
  );

  assign NRT_EXPIRED = nrt_expire;
  assign GPT_EXPIRED = gpt_expire;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      FIELD_OFF <= 1'b0;
    end else begin
      FIELD_OFF <= gpt_expire && field_trig_q;
    end
  end

  // Sticky events; a new event in the clearing read cycle survives
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || CMD_SET_DEFAULT) begin
      ev_nre_q <= 1'b0;
      ev_gpe_q <= 1'b0;
    end else begin
      ev_nre_q <= nrt_expire || (ev_nre_q && !status_read);
      ev_gpe_q <= gpt_expire || (ev_gpe_q && !status_read);
    end
  end

  assign tim_summary = (ev_nre_q && !mask_q[`RFET_MASK_NRE]) ||
    (ev_gpe_q && !mask_q[`RFET_MASK_GPE]);

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      TIMER_IRQ <= 1'b0;
    end else begin
      TIMER_IRQ <= tim_summary;
    end
  end

  sequence s_plain_tx_end;
    TX_END && !NFC_MODE && !ACTIVE_P2P && !CMD_START_NRT && !CMD_SET_DEFAULT && !nrt_zero;
  endsequence
  sequence s_nrt_run_next;
    ##1 NRT_RUNNING;
  endsequence

  property p_tx_end_starts;
    @(posedge CORE_CLK) disable iff (!RST_N)
      s_plain_tx_end |-> s_nrt_run_next;
  endproperty
  a_tx_end_starts: assert property (p_tx_end_starts)
    else $error("response timer not started at transmission end");

  property p_zero_never_runs;
    @(posedge CORE_CLK) disable iff (!RST_N)
      nrt_zero && !NRT_RUNNING |=> !NRT_RUNNING;
  endproperty
  a_zero_never_runs: assert property (p_zero_never_runs)
    else $error("response timer started with zero timeout");

  property p_fine_step;
    @(posedge CORE_CLK) disable iff (!RST_N)
      nrt_tick && !ctrl_q[`RFET_CTRL_STEP] |-> nrt_pre_q[5:0] == 6'h3f;
  endproperty
  a_fine_step: assert property (p_fine_step)
    else $error("fine response step not every 64 periods");
  property p_coarse_step;
    @(posedge CORE_CLK) disable iff (!RST_N)
      nrt_tick && ctrl_q[`RFET_CTRL_STEP] |-> nrt_pre_q == 12'hfff;
  endproperty
  a_coarse_step: assert property (p_coarse_step)
    else $error("coarse response step not every 4096 periods");
  property p_gpt_step;
    @(posedge CORE_CLK) disable iff (!RST_N)
      gpt_tick |-> FC_EN && gpt_pre_q == 3'h7;
  endproperty
  a_gpt_step: assert property (p_gpt_step)
    else $error("general step not every 8 periods");

  property p_nfc_waits_field;
    @(posedge CORE_CLK) disable iff (!RST_N)
      NFC_MODE && !ACTIVE_P2P && !field_on_q && !CMD_START_NRT && !NRT_RUNNING
        |=> !NRT_RUNNING;
  endproperty
  a_nfc_waits_field: assert property (p_nfc_waits_field)
    else $error("NFC response timer started without field");

  property p_p2p_tx_off;
    @(posedge CORE_CLK) disable iff (!RST_N)
      ACTIVE_P2P && TX_OFF && !nrt_zero && !CMD_SET_DEFAULT |=> NRT_RUNNING;
  endproperty
  a_p2p_tx_off: assert property (p_p2p_tx_off)
    else $error("peer mode timer not started at transmitter off");

  property p_set_default;
    @(posedge CORE_CLK) disable iff (!RST_N)
      CMD_SET_DEFAULT |=> nrt_val == 16'h0000 && ctrl_q == 8'h00 && !NRT_RUNNING;
  endproperty
  a_set_default: assert property (p_set_default)
    else $error("set-default did not clear timer registers");

  property p_code_zero_cmd_only;
    @(posedge CORE_CLK) disable iff (!RST_N)
      trig == `RFET_TRIG_CMD && !CMD_START_GPT && !GPT_RUNNING && !CMD_SET_DEFAULT
        |=> !GPT_RUNNING;
  endproperty
  a_code_zero_cmd_only: assert property (p_code_zero_cmd_only)
    else $error("general timer started without command");

  property p_field_off;
    @(posedge CORE_CLK) disable iff (!RST_N)
      FIELD_OFF |-> $past(gpt_expire) && $past(field_trig_q);
  endproperty
  a_field_off: assert property (p_field_off)
    else $error("field switched off without its trigger");

  property p_event_sticky;
    @(posedge CORE_CLK) disable iff (!RST_N)
      nrt_expire && !CMD_SET_DEFAULT |=> ev_nre_q;
  endproperty
  a_event_sticky: assert property (p_event_sticky)
    else $error("no-response event lost");

  property p_mask;
    @(posedge CORE_CLK) disable iff (!RST_N)
      mask_q[`RFET_MASK_NRE] && !ev_gpe_q |=> !TIMER_IRQ;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked response expiry raised interrupt");

endmodule // rfet_timers

// *** tb/rfet_timers_tb.sv ***
`include "rfet_map.svh"

module rfet_timers_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic CORE_CLK = 0, RST_N = 0, FC_EN = 1, REG_WE = 0, REG_RE = 0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, rd_v;
  logic CMD_SET_DEFAULT = 0, CMD_START_NRT = 0, CMD_START_GPT = 0;
  logic NFC_MODE = 0, ACTIVE_P2P = 0, EXT_FIELD = 0;
  logic TX_END = 0, TX_OFF = 0, RX_START = 0, RX_END = 0;
  logic NRT_EXPIRED, GPT_EXPIRED, FIELD_OFF, NRT_RUNNING, GPT_RUNNING, TIMER_IRQ;
  int fails = 0, compares = 0, cycles = 0, base, gbase, n;

  rfet_timers DUT (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .FC_EN(FC_EN), .REG_WE(REG_WE),
    .REG_RE(REG_RE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .CMD_SET_DEFAULT(CMD_SET_DEFAULT), .CMD_START_NRT(CMD_START_NRT),
    .CMD_START_GPT(CMD_START_GPT), .NFC_MODE(NFC_MODE), .ACTIVE_P2P(ACTIVE_P2P),
    .EXT_FIELD(EXT_FIELD), .TX_END(TX_END), .TX_OFF(TX_OFF), .RX_START(RX_START),
    .RX_END(RX_END), .NRT_EXPIRED(NRT_EXPIRED), .GPT_EXPIRED(GPT_EXPIRED),
    .FIELD_OFF(FIELD_OFF), .NRT_RUNNING(NRT_RUNNING), .GPT_RUNNING(GPT_RUNNING),
    .TIMER_IRQ(TIMER_IRQ));

  always #50 CORE_CLK = ~CORE_CLK;

  task print_verdict;
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Longest scenario is the coarse step run of about 4100 cycles
  always @(posedge CORE_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      print_verdict;
    end
  end

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Inputs always change 10 ns after the rising edge
  task tick(input int k);
    repeat (k) @(posedge CORE_CLK);
    #10;
  endtask

  task automatic pulse(ref logic s);
    s = 1;
    tick(1);
    s = 0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    REG_WE = 1;
    REG_ADDR = a;
    REG_WDATA = d;
    tick(1);
    REG_WE = 0;
    // Idle cycle so a following access never retoggles the strobe in one step
    tick(1);
  endtask

  task rd(input logic [7:0] a, output logic [7:0] d);
    REG_RE = 1;
    REG_ADDR = a;
    tick(1);
    REG_RE = 0;
    d = REG_RDATA;
    tick(1);
  endtask

  task set_nrt(input logic [15:0] v);
    wr(`RFET_ADDR_NRT_HI, v[15:8]);
    wr(`RFET_ADDR_NRT_LO, v[7:0]);
  endtask

  task automatic wait_exp(input bit g, input int lim, output int k);
    k = 0;
    while ((g ? GPT_EXPIRED : NRT_EXPIRED) !== 1'b1 && k < lim) begin
      tick(1);
      k++;
    end
  endtask

  task t_defaults;
    chk({NRT_RUNNING, GPT_RUNNING, TIMER_IRQ}, 16'h0000);
    rd(`RFET_ADDR_NRT_HI, rd_v); chk(rd_v, 16'h0000);
    rd(`RFET_ADDR_NRT_LO, rd_v); chk(rd_v, 16'h0000);
    rd(`RFET_ADDR_CTRL, rd_v); chk(rd_v, 16'h0000);
    wr(`RFET_ADDR_CTRL, 8'hff);
    rd(`RFET_ADDR_CTRL, rd_v); chk(rd_v, 16'h00e3);
    wr(`RFET_ADDR_GPT_HI, 8'ha5);
    wr(`RFET_ADDR_GPT_LO, 8'h5a);
    rd(`RFET_ADDR_GPT_HI, rd_v); chk(rd_v, 16'h00a5);
    rd(`RFET_ADDR_GPT_LO, rd_v); chk(rd_v, 16'h005a);
    rd(8'h20, rd_v); chk(rd_v, 16'h0000);
    set_nrt(16'h1234);
    pulse(CMD_SET_DEFAULT);
    rd(`RFET_ADDR_NRT_HI, rd_v); chk(rd_v, 16'h0000);
    rd(`RFET_ADDR_NRT_LO, rd_v); chk(rd_v, 16'h0000);
    rd(`RFET_ADDR_CTRL, rd_v); chk(rd_v, 16'h0000);
  endtask

  task t_zero;
    pulse(TX_END);
    pulse(CMD_START_NRT);
    tick(2);
    chk(NRT_RUNNING, 1'b0);
  endtask

  // Differences between runs cancel the start latency, so the unit is checked exactly
  task t_steps;
    set_nrt(16'h0001);
    pulse(TX_END);
    chk(NRT_RUNNING, 1'b1);
    wait_exp(0, 200, base);
    chk(base >= 63 && base <= 66, 1'b1);
    chk(NRT_RUNNING, 1'b0);
    set_nrt(16'h0002);
    pulse(TX_END);
    wait_exp(0, 300, n);
    chk(n - base, 16'd64);
    set_nrt(16'h0001);
    wr(`RFET_ADDR_CTRL, 8'h01);
    pulse(TX_END);
    wait_exp(0, 5000, n);
    chk(n - base, 16'd4032);
    wr(`RFET_ADDR_CTRL, 8'h00);
  endtask

  task t_restart;
    pulse(TX_END);
    tick(30);
    pulse(CMD_START_NRT);
    wait_exp(0, 200, n);
    chk(n, base);
  endtask

  task t_reply;
    pulse(TX_END);
    tick(10);
    pulse(RX_START);
    wait_exp(0, 100, n);
    chk(NRT_EXPIRED, 1'b0);
    wr(`RFET_ADDR_CTRL, 8'h02);
    pulse(TX_END);
    tick(10);
    pulse(RX_START);
    wait_exp(0, 100, n);
    chk(NRT_EXPIRED, 1'b1);
    wr(`RFET_ADDR_CTRL, 8'h00);
  endtask

  task t_modes;
    NFC_MODE = 1;
    pulse(TX_END);
    tick(8);
    chk(NRT_RUNNING, 1'b0);
    EXT_FIELD = 1;
    tick(8);
    chk(NRT_RUNNING, 1'b1);
    wait_exp(0, 200, n);
    NFC_MODE = 0;
    ACTIVE_P2P = 1;
    pulse(TX_END);
    tick(3);
    chk(NRT_RUNNING, 1'b0);
    pulse(TX_OFF);
    chk(NRT_RUNNING, 1'b1);
    wait_exp(0, 200, n);
    ACTIVE_P2P = 0;
  endtask

  task t_irq;
    wr(`RFET_ADDR_MASK, 8'h00);
    rd(`RFET_ADDR_MAIN_IRQ, rd_v);
    tick(3);
    pulse(TX_END);
    wait_exp(0, 200, n);
    tick(3);
    chk(TIMER_IRQ, 1'b1);
    rd(`RFET_ADDR_MAIN_IRQ, rd_v);
    chk(rd_v & 8'h02, 16'h0002);
    tick(2);
    chk(TIMER_IRQ, 1'b0);
    wr(`RFET_ADDR_MASK, 8'h40);
    rd(`RFET_ADDR_MASK, rd_v); chk(rd_v, 16'h0040);
    pulse(TX_END);
    wait_exp(0, 200, n);
    tick(3);
    chk(TIMER_IRQ, 1'b0);
  endtask

  task t_gpt;
    wr(`RFET_ADDR_GPT_HI, 8'h00);
    wr(`RFET_ADDR_GPT_LO, 8'h01);
    pulse(RX_END);
    pulse(RX_START);
    tick(2);
    chk(GPT_RUNNING, 1'b0);
    pulse(CMD_START_GPT);
    wait_exp(1, 100, gbase);
    chk(gbase >= 7 && gbase <= 10, 1'b1);
    for (int c = 1; c < 4; c++) begin
      wr(`RFET_ADDR_CTRL, 8'(c << 5));
      wr(`RFET_ADDR_GPT_LO, 8'(c + 1));
      NFC_MODE = (c == 3);
      case (c)
        1: pulse(RX_END);
        2: pulse(RX_START);
        default: pulse(TX_END);
      endcase
      wait_exp(1, 100, n);
      chk(n - gbase, 16'(8 * c));
      tick(1);
      chk(FIELD_OFF, c == 3);
      NFC_MODE = 0;
    end
    for (int c = 4; c < 8; c++) begin
      wr(`RFET_ADDR_CTRL, 8'(c << 5));
      NFC_MODE = 1;
      pulse(RX_END);
      pulse(RX_START);
      pulse(TX_END);
      tick(2);
      chk(GPT_RUNNING, 1'b0);
      NFC_MODE = 0;
    end
    wr(`RFET_ADDR_GPT_LO, 8'h01);
    pulse(CMD_START_GPT);
    n = 0;
    // Carrier enable at half rate: a unit must take twice as many clocks
    while (GPT_EXPIRED !== 1'b1 && n < 100) begin
      FC_EN = ~FC_EN;
      tick(1);
      n++;
    end
    FC_EN = 1;
    chk(n, 16'(2 * gbase));
  endtask

  initial begin
    tick(6);
    RST_N = 1;
    tick(4);
    t_defaults();
    t_zero();
    t_steps();
    t_restart();
    t_reply();
    t_modes();
    t_irq();
    t_gpt();
    print_verdict;
  end
endmodule // rfet_timers_tb
